// [rtl/dhif_defines.vh]
// dhif_defines.vh: constants for the display host interface front end
// assumes: included by the front end only, no other users
`ifndef DHIF_DEFINES_VH
`define DHIF_DEFINES_VH
`define DHIF_ADDR_HI 6'h1E
`define DHIF_CTRL_CONT_BIT 7
`define DHIF_CTRL_DC_BIT 6
`define DHIF_BIT_CNT_LAST 3'h7
`define DHIF_BIT_CNT_ZERO 3'h0
`define DHIF_COL_W 7
`define DHIF_COL_ONE 7'h01
`define DHIF_COL_RESET 7'h00
`define DHIF_FIFO_DEPTH 16
`define DHIF_FIFO_AW 4
`define DHIF_PIN_N 5
`define DHIF_PIN_STRAP 4
`define DHIF_PIN_CSN 3
`define DHIF_PIN_DC 2
`define DHIF_PIN_SCL 1
`define DHIF_PIN_SDA 0
`endif

// [rtl/dhif_fifo.v]
// dhif_fifo.v: synchronous fifo for received bytes with data/command tag
// assumes: single clock, clock enable freezes all state
`default_nettype none
module dhif_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  reg has_q;
  // the output register is one of the words, so the whole fifo holds DEPTH
  localparam integer DEPTH_I = DEPTH;
  wire empty = (wr_q == rd_q);
  wire [AW+1:0] fill = {1'b0, wr_q - rd_q} + {{(AW+1){1'b0}}, has_q};
  wire full = (fill >= DEPTH_I[AW+1:0]);
  wire push = in_valid && !full;
  wire pop = out_valid && out_ready;
  assign in_ready = !full;
  assign out_valid = has_q;
  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  // output register refills from memory whenever it is drained or empty
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
      has_q <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (push) begin
        wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
      end
      if ((!has_q || pop) && !empty) begin
        out_data <= mem_q[rd_q[AW-1:0]];
        rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
        has_q <= 1'b1;
      end else if (pop) begin
        has_q <= 1'b0;
      end
    end
  end
endmodule // dhif_fifo
`default_nettype wire

// [rtl/dhif_front_end.v]
// dhif_front_end.v: host serial front end (4-line spi or i2c slave write port)
// assumes: host drives link clock slower than ref_clk/4; pins are asynchronous
//
// Behaviour
// - strap low selects spi, high selects i2c
// - only accept transfers while chip select low
// - low hard init resets whole front end
// - data_command_sel high data, low command
// - i2c mode: dc pin is address lsb
// - spi mode: line zero is serial clock
// - spi: line one data in, line two unused
// - i2c: lines one/two form sda, zero scl
// - slave address fixed except lsb select
// - rw bit one read, zero write
// - control byte: continuation, dc, six zeros
// - column pointer increments after each data write
`default_nettype none
`include "dhif_defines.vh"
module dhif_front_end #(
  parameter COL_W = `DHIF_COL_W,
  parameter FIFO_DEPTH = `DHIF_FIFO_DEPTH,
  parameter FIFO_AW = `DHIF_FIFO_AW
) (
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  input wire hard_init_n,
  input wire port_select_strap,
  input wire chip_select_n,
  input wire data_command_sel,
  input wire serial_line_zero,
  input wire serial_line_one,
  output wire sda_out,
  output wire sda_oe_n,
  output wire byte_valid,
  input wire byte_ready,
  output wire [7:0] byte_data,
  output wire byte_is_data,
  output reg [COL_W-1:0] col_ptr_q,
  output reg read_req_q,
  output reg i2c_mode_q
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  wire [`DHIF_PIN_N-1:0] pin_raw;
  wire [`DHIF_PIN_N-1:0] pin_s;
  reg [1:0] init_s_q;
  wire rst_all_n = reset_n & init_s_q[1];
  assign pin_raw[`DHIF_PIN_STRAP] = port_select_strap;
  assign pin_raw[`DHIF_PIN_CSN] = chip_select_n;
  assign pin_raw[`DHIF_PIN_DC] = data_command_sel;
  assign pin_raw[`DHIF_PIN_SCL] = serial_line_zero;
  assign pin_raw[`DHIF_PIN_SDA] = serial_line_one;
  // init pin has its own pair: it feeds the reset of everything else
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_s_q <= 2'h0;
    end else if (clk_en) begin
      init_s_q <= {init_s_q[0], hard_init_n};
    end
  end
  // pipelines idle high; only spi clock idles low, and spi ignores falls
  genvar gi;
  generate
    for (gi = 0; gi < `DHIF_PIN_N; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge ref_clk or negedge rst_all_n) begin
        if (!rst_all_n) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
        end else if (clk_en) begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
        end
      end
      assign pin_s[gi] = s2_q;
    end
  endgenerate
  wire strap_s = pin_s[`DHIF_PIN_STRAP];
  wire csn_s = pin_s[`DHIF_PIN_CSN];
  wire dc_s = pin_s[`DHIF_PIN_DC];
  wire clk_s = pin_s[`DHIF_PIN_SCL];
  wire sda_s = pin_s[`DHIF_PIN_SDA];
  reg clk_d1_q;
  reg sda_d1_q;
  wire clk_rise = clk_s && !clk_d1_q;
  wire clk_fall = !clk_s && clk_d1_q;
  wire i2c_start = i2c_mode_q && clk_s && clk_d1_q && sda_d1_q && !sda_s;
  wire i2c_stop = i2c_mode_q && clk_s && clk_d1_q && !sda_d1_q && sda_s;
  // ----------------------------------------
  // receive state
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CTRL = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_SPI = 3'h4;
  localparam ST_SKIP = 3'h5;
  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg ack_q;
  reg cont_q;
  reg dc_q;
  reg strap_seen_q;
  reg [1:0] fill_q;
  reg sh_valid_q;
  reg push_q;
  reg [8:0] push_data_q;
  wire fifo_in_ready;
  wire [7:0] byte_now = {sh_q[6:0], sda_s};
  wire last_bit = (bit_q == `DHIF_BIT_CNT_LAST);
  wire [6:0] my_addr = {`DHIF_ADDR_HI, dc_s};
  function is_ctrl_ok;
    input [7:0] b;
    begin
      is_ctrl_ok = (b[5:0] == 6'h00);
    end
  endfunction
  // states in which a byte is being shifted toward a decision
  function rx_active;
    input [2:0] st;
    begin
      rx_active = (st != ST_IDLE) && (st != ST_SKIP);
    end
  endfunction
  assign sda_out = 1'b0;
  assign sda_oe_n = !ack_q;
  always @(posedge ref_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      st_q <= ST_IDLE;
      bit_q <= `DHIF_BIT_CNT_ZERO;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      cont_q <= 1'b0;
      dc_q <= 1'b0;
      clk_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      strap_seen_q <= 1'b0;
      fill_q <= 2'h0;
      i2c_mode_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 9'h000;
      read_req_q <= 1'b0;
    end else if (clk_en) begin
      clk_d1_q <= clk_s;
      sda_d1_q <= sda_s;
      push_q <= 1'b0;
      fill_q <= {fill_q[0], 1'b1};
      // strap pipeline shows its reset value until two samples have passed
      if (!strap_seen_q && fill_q[1]) begin
        strap_seen_q <= 1'b1;
        i2c_mode_q <= strap_s;
      end
      if (!i2c_mode_q) begin
        if (csn_s || !strap_seen_q) begin
          st_q <= ST_SPI;
          bit_q <= `DHIF_BIT_CNT_ZERO;
        end else if (clk_rise) begin
          sh_q <= byte_now;
          bit_q <= bit_q + 3'h1;
          if (last_bit) begin
            push_q <= fifo_in_ready;
            push_data_q <= {dc_s, byte_now};
          end
        end
      end else if (csn_s || i2c_stop) begin
        st_q <= ST_IDLE;
        ack_q <= 1'b0;
      end else if (i2c_start) begin
        st_q <= ST_ADDR;
        bit_q <= `DHIF_BIT_CNT_ZERO;
        ack_q <= 1'b0;
      end else begin
        if (clk_fall && ack_q) begin
          ack_q <= 1'b0;
          bit_q <= `DHIF_BIT_CNT_ZERO;
        end else if (clk_rise && !ack_q && rx_active(st_q)) begin
          sh_q <= byte_now;
          bit_q <= bit_q + 3'h1;
        end
        // ack is driven from the falling edge after the eighth bit
        if (clk_fall && !ack_q && bit_q == `DHIF_BIT_CNT_ZERO && rx_active(st_q) && sh_valid_q) begin
          case (st_q)
            ST_ADDR: begin
              if (sh_q[7:1] == my_addr) begin
                ack_q <= 1'b1;
                read_req_q <= sh_q[0];
                st_q <= sh_q[0] ? ST_SKIP : ST_CTRL;
              end else begin
                st_q <= ST_SKIP;
              end
            end
            ST_CTRL: begin
              if (is_ctrl_ok(sh_q)) begin
                ack_q <= 1'b1;
                cont_q <= sh_q[`DHIF_CTRL_CONT_BIT];
                dc_q <= sh_q[`DHIF_CTRL_DC_BIT];
                st_q <= ST_DATA;
              end else begin
                st_q <= ST_SKIP;
              end
            end
            ST_DATA: begin
              ack_q <= fifo_in_ready;
              push_q <= fifo_in_ready;
              push_data_q <= {dc_q, sh_q};
              st_q <= cont_q ? ST_CTRL : ST_DATA;
            end
            default: begin
              st_q <= ST_SKIP;
            end
          endcase
        end
      end
    end
  end
  // marks that eight bits have been shifted since the last byte boundary
  always @(posedge ref_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      sh_valid_q <= 1'b0;
    end else if (clk_en) begin
      if (i2c_start || ack_q) begin
        sh_valid_q <= 1'b0;
      end else if (clk_rise && last_bit && i2c_mode_q) begin
        sh_valid_q <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // byte fifo and column pointer
  // ----------------------------------------
  wire [8:0] fifo_out;
  dhif_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(rst_all_n),
    .clk_en(clk_en),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(byte_valid),
    .out_ready(byte_ready),
    .out_data(fifo_out)
  );
  assign byte_data = fifo_out[7:0];
  assign byte_is_data = fifo_out[8];
  always @(posedge ref_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      col_ptr_q <= `DHIF_COL_RESET;
    end else if (clk_en && byte_valid && byte_ready && byte_is_data) begin
      col_ptr_q <= col_ptr_q + `DHIF_COL_ONE;
    end
  end
endmodule // dhif_front_end
`default_nettype wire

// [test/dhif_front_end_sva.sv]
// dhif_front_end_sva.sv: port checks for the host serial front end
// assumes: bound into dhif_front_end, one ref_clk domain
`default_nettype none
module dhif_sva #(
  parameter COL_W = 7
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic hard_init_n,
  input wire logic port_select_strap,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic byte_valid,
  input wire logic byte_ready,
  input wire logic [7:0] byte_data,
  input wire logic byte_is_data,
  input wire logic [COL_W-1:0] col_ptr_q,
  input wire logic i2c_mode_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_sda; sda_out == 1'b0; endproperty
  a_sda: assert property (p_sda) else $error("sda out high");
  property p_spi; !i2c_mode_q |-> sda_oe_n; endproperty
  a_spi: assert property (p_spi) else $error("sda driven in spi");
  // init pin is synchronised, so require it high now and one sample back before trusting it
  property p_hold; byte_valid && !byte_ready && hard_init_n && $past(hard_init_n)
    |=> byte_valid && $stable({byte_is_data, byte_data}); endproperty
  a_hold: assert property (p_hold) else $error("byte changed before taken");
  property p_inc; clk_en && byte_valid && byte_ready && byte_is_data && hard_init_n && $past(hard_init_n)
    |=> col_ptr_q == $past(col_ptr_q) + 1'b1; endproperty
  a_inc: assert property (p_inc) else $error("column not advanced");
  property p_col; $changed(col_ptr_q)
    |-> col_ptr_q == '0 || $past(clk_en && byte_valid && byte_ready && byte_is_data); endproperty
  a_col: assert property (p_col) else $error("column moved without data");
  property p_init; !hard_init_n [*4] |-> !byte_valid && sda_oe_n && col_ptr_q == '0; endproperty
  a_init: assert property (p_init) else $error("init pin ignored");
  property p_mode; $changed(i2c_mode_q) |-> i2c_mode_q == port_select_strap; endproperty
  a_mode: assert property (p_mode) else $error("mode differs from strap");
  property p_ack; $fell(sda_oe_n) |-> !sda_oe_n [*3]; endproperty
  a_ack: assert property (p_ack) else $error("ack too short");
  property p_freeze; !clk_en |=> $stable(col_ptr_q) && $stable(byte_valid) && $stable(i2c_mode_q); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule // dhif_sva
bind dhif_front_end dhif_sva #(.COL_W(COL_W)) dhif_sva_i (.ref_clk, .reset_n, .clk_en, .hard_init_n,
  .port_select_strap, .sda_out, .sda_oe_n, .byte_valid, .byte_ready, .byte_data, .byte_is_data, .col_ptr_q, .i2c_mode_q);
`default_nettype wire

// [test/dhif_front_end_tb.sv]
// dhif_front_end_tb.sv: self-checking bench for the host serial front end
// assumes: host model drives the pins, bench consumes the byte stream
`default_nettype none
module dhif_front_end_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, hard_init_n = 1'b1, port_select_strap = 1'b0;
  logic data_command_sel = 1'b0, byte_ready = 1'b0, stall = 1'b0, ack;
  logic [15:0] seed = 16'hE3B2;
  logic [6:0] col_exp = 7'h00;
  logic [8:0] got;
  logic [8:0] exp_q[$];
  int n_errors = 0, comparisons = 0, cycles = 0;
  wire logic serial_line_zero, chip_select_n, sdo, sda_out, sda_oe_n, byte_valid, byte_is_data, read_req_q, i2c_mode_q;
  wire logic [7:0] byte_data;
  wire logic [6:0] col_ptr_q;
  wire logic serial_line_one = sdo & (sda_oe_n | sda_out);
  dhif_front_end dhif_front_end_i (.ref_clk, .reset_n, .clk_en, .hard_init_n, .port_select_strap, .chip_select_n,
    .data_command_sel, .serial_line_zero, .serial_line_one, .sda_out, .sda_oe_n, .byte_valid, .byte_ready,
    .byte_data, .byte_is_data, .col_ptr_q, .read_req_q, .i2c_mode_q);
  dhif_host_model dhif_host_model_i (.serial_line_zero, .chip_select_n, .sdo, .serial_line_one);
  always #20 ref_clk = ~ref_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // consumer stalls at random, and holds off while stall is set so the fifo really backs up
  always @(posedge ref_clk) begin
    seed <= lfsr(seed);
    byte_ready <= !stall && (seed[0] | seed[1]);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      conclude();
    end
    if (reset_n && clk_en && byte_valid && byte_ready) begin
      if (exp_q.size() == 0) check("spare byte", 9'h000, 9'h001);
      else begin
        got = exp_q.pop_front();
        check("byte", {byte_is_data, byte_data}, got);
        check("column", {2'b00, col_ptr_q}, {2'b00, col_exp});
        if (got[8]) col_exp = col_exp + 7'h01;
      end
    end
  end
  task automatic restart(input logic mode);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    port_select_strap <= mode;
    data_command_sel <= 1'b1;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    col_exp = 7'h00;
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic drain;
    for (int k = 0; k < 600 && exp_q.size() != 0; k++) @(posedge ref_clk);
    check("left over", 9'(exp_q.size()), 9'h000);
  endtask
  task automatic send_spi(input logic [7:0] b, input logic d, input logic keep);
    @(posedge ref_clk);
    data_command_sel <= d;
    if (keep) exp_q.push_back({d, b});
    dhif_host_model_i.spi_byte(b, 1'b1);
  endtask
  task automatic send_i2c(input logic [7:0] b, input logic want);
    dhif_host_model_i.i2c_byte(b, ack);
    check("ack", {8'h00, ack}, {8'h00, want});
  endtask
  initial begin
    restart(1'b0);
    for (int i = 0; i < 24; i++) begin
      send_spi(seed[7:0], seed[8], 1'b1);
      if (i == 12) dhif_host_model_i.spi_byte(8'h3C, 1'b0);
    end
    drain();
    $display("test spi done");
    @(posedge ref_clk) stall <= 1'b1;
    for (int i = 0; i < 17; i++) send_spi(8'h80 + i[7:0], 1'b1, i < 16);
    @(posedge ref_clk) begin
      stall <= 1'b0;
      clk_en <= 1'b0;
    end
    repeat (20) @(posedge ref_clk);
    check("frozen", {1'b0, byte_valid, col_ptr_q}, {2'b01, col_exp});
    clk_en <= 1'b1;
    drain();
    $display("test fifo done");
    @(posedge ref_clk) hard_init_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("init", {byte_valid, sda_oe_n, col_ptr_q}, 9'h080);
    hard_init_n <= 1'b1;
    col_exp = 7'h00;
    repeat (10) @(posedge ref_clk);
    $display("test init done");
    restart(1'b1);
    check("mode", {8'h00, i2c_mode_q}, 9'h001);
    dhif_host_model_i.i2c_start();
    send_i2c(8'h78, 1'b0);
    dhif_host_model_i.i2c_stop();
    dhif_host_model_i.i2c_start();
    send_i2c(8'h7A, 1'b1);
    send_i2c(8'h80, 1'b1);
    exp_q.push_back(9'h0AE);
    send_i2c(8'hAE, 1'b1);
    send_i2c(8'h40, 1'b1);
    exp_q.push_back(9'h112);
    exp_q.push_back(9'h134);
    send_i2c(8'h12, 1'b1);
    send_i2c(8'h34, 1'b1);
    dhif_host_model_i.i2c_stop();
    dhif_host_model_i.i2c_start();
    send_i2c(8'h7B, 1'b1);
    dhif_host_model_i.i2c_stop();
    check("read", {8'h00, read_req_q}, 9'h001);
    dhif_host_model_i.i2c_start();
    send_i2c(8'h7A, 1'b1);
    send_i2c(8'h41, 1'b0);
    dhif_host_model_i.i2c_stop();
    drain();
    $display("test i2c done");
    conclude();
  end
endmodule // dhif_front_end_tb
`default_nettype wire

// [test/dhif_host_model.sv]
// dhif_host_model.sv: host driving spi frames or i2c writes on the serial pins
// assumes: device samples the pins asynchronously, link clock 320 ns
`default_nettype none
module dhif_host_model (
  output logic serial_line_zero,
  output logic chip_select_n,
  output logic sdo,
  input wire logic serial_line_one
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serial_line_zero = 1'b0;
    chip_select_n = 1'b1;
    sdo = 1'b1;
  end
  task automatic bit_out(input logic b);
    sdo = b;
    #160 serial_line_zero = 1'b1;
    #160 serial_line_zero = 1'b0;
  endtask
  task automatic spi_byte(input logic [7:0] b, input logic sel);
    chip_select_n = ~sel;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    #160 chip_select_n = 1'b1;
    sdo = ~sdo; // released line must not look held
  endtask
  task automatic i2c_start;
    chip_select_n = 1'b0;
    sdo = 1'b1;
    serial_line_zero = 1'b1;
    #160 sdo = 1'b0;
    #160 serial_line_zero = 1'b0;
  endtask
  task automatic i2c_stop;
    sdo = 1'b0;
    #160 serial_line_zero = 1'b1;
    #160 sdo = 1'b1;
    chip_select_n = 1'b1;
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    sdo = 1'b1;
    #160 serial_line_zero = 1'b1;
    #150 ack = ~serial_line_one;
    #10 serial_line_zero = 1'b0;
  endtask
endmodule // dhif_host_model
`default_nettype wire
